// *** hw/csd_calendar.sv ***
/*
 Clock/calendar with a load request and a difference request.
 Assumes requests and tables are synchronous to clk and tables stay
 stable while their request is high.
*/
`timescale 1ns/1ns
`default_nettype none
module csd_calendar #(
    parameter int SEC_CYCLES = csd_pkg::SEC_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   calendar_load_request,
    input  wire csd_pkg::csd_table_type load_table,
    input  wire logic                   calendar_difference_request,
    input  wire csd_pkg::csd_table_type subtrahend_table,
    output logic                        load_error,
    output logic                        diff_error,
    output logic                        diff_busy,
    output logic                        diff_done,
    output csd_pkg::csd_table_type      diff_result,
    output csd_pkg::csd_table_type      current_time,
    output logic [2:0]                  day_of_week
);
    csd_pkg::csd_state_type state_reg;
    csd_pkg::csd_time_type  now_reg, now_next, tick_time, res_reg, load_time;
    csd_pkg::csd_table_type now_table, cur_tab_reg, diff_result_reg;
    logic [31:0] tick_cnt_reg;
    logic        load_req_d_reg, diff_req_d_reg, load_error_reg, diff_error_reg, done_reg;
    logic [1:0]  stage_reg;
    logic [16:0] rem_reg, hold_sec_reg, divisor;
    logic [6:0]  q_reg;
    logic [2:0]  dow_reg, load_dow, now_dow;
    logic        load_ok, sub_ok;
    logic [15:0] sub_day, now_day;
    logic [16:0] sub_sec, now_sec;

    // ----------------------------------------------------------------
    // Table checkers
    // ----------------------------------------------------------------
    assign now_table = csd_pkg::to_table(now_reg);

    csd_date_check u_load (
        .table_in   (load_table),
        .valid      (load_ok),
        .time_out   (load_time),
        .day_num    (),
        .sec_of_day (),
        .dow        (load_dow)
    );
    csd_date_check u_sub (
        .table_in   (subtrahend_table),
        .valid      (sub_ok),
        .time_out   (),
        .day_num    (sub_day),
        .sec_of_day (sub_sec),
        .dow        ()
    );
    csd_date_check u_now (
        .table_in   (now_table),
        .valid      (),
        .time_out   (),
        .day_num    (now_day),
        .sec_of_day (now_sec),
        .dow        (now_dow)
    );

    // ----------------------------------------------------------------
    // Request edges
    // ----------------------------------------------------------------
    // Edge triggered so a held request does not freeze the clock
    wire tick    = (tick_cnt_reg == 32'(SEC_CYCLES - 1));
    wire idle    = (state_reg == csd_pkg::CSD_IDLE);
    wire load_go = calendar_load_request & ~load_req_d_reg;
    wire diff_go = calendar_difference_request & ~diff_req_d_reg & idle;
    wire load_do = load_go & load_ok;
    wire diff_do = diff_go & sub_ok;

    // ----------------------------------------------------------------
    // Timekeeping
    // ----------------------------------------------------------------
    wire [4:0] dim = csd_pkg::days_in_month(now_reg.year, now_reg.month);

    always_comb begin
        tick_time        = now_reg;
        tick_time.second = now_reg.second + 6'h01;
        if (now_reg.second == 6'h3b) begin
            tick_time.second = 6'h00;
            tick_time.minute = now_reg.minute + 6'h01;
            if (now_reg.minute == 6'h3b) begin
                tick_time.minute = 6'h00;
                tick_time.hour   = now_reg.hour + 5'h01;
                if (now_reg.hour == 5'h17) begin
                    tick_time.hour = 5'h00;
                    tick_time.day  = now_reg.day + 5'h01;
                    if (now_reg.day == dim) begin
                        tick_time.day   = 5'h01;
                        tick_time.month = now_reg.month + 4'h1;
                        if (now_reg.month == 4'hc) begin
                            tick_time.month = 4'h1;
                            tick_time.year  = (now_reg.year == 7'h63) ? 7'h00 : now_reg.year + 7'h01;
                        end
                    end
                end
            end
        end
    end

    // An invalid table never reaches the clock
    assign now_next = load_do ? load_time : (tick ? tick_time : now_reg);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            now_reg      <= csd_pkg::TIME_RESET;
            tick_cnt_reg <= 32'h00000000;
            cur_tab_reg  <= '0;
            dow_reg      <= 3'h0;
        end else begin
            now_reg      <= now_next;
            // A load restarts the second so it runs a full period
            tick_cnt_reg <= (tick || load_do) ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
            cur_tab_reg  <= csd_pkg::to_table(now_next);
            dow_reg      <= now_dow;
        end
    end

    // ----------------------------------------------------------------
    // Error flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_req_d_reg <= 1'b0;
            diff_req_d_reg <= 1'b0;
            load_error_reg <= 1'b0;
            diff_error_reg <= 1'b0;
        end else begin
            load_req_d_reg <= calendar_load_request;
            diff_req_d_reg <= calendar_difference_request;
            load_error_reg <= calendar_load_request & ~load_ok;
            diff_error_reg <= calendar_difference_request & ~sub_ok;
        end
    end

    // ----------------------------------------------------------------
    // Difference: elapsed days and seconds, then split by division
    // ----------------------------------------------------------------
    wire        sec_borrow = (now_sec < sub_sec);
    wire [16:0] sec_diff   = now_sec - sub_sec + (sec_borrow ? csd_pkg::SECS_PER_DAY : 17'h00000);
    wire [16:0] day_need   = 17'(sub_day) + 17'(sec_borrow);
    // A later subtrahend is outside the contract; it yields an all-zero result
    wire        future     = (day_need > 17'(now_day));
    wire [16:0] day_diff   = 17'(now_day) - day_need;

    always_comb begin
        unique case (stage_reg)
            2'h0: divisor = csd_pkg::DAYS_PER_YEAR;
            2'h1: divisor = csd_pkg::DAYS_PER_MONTH;
            2'h2: divisor = csd_pkg::SECS_PER_HOUR;
            2'h3: divisor = csd_pkg::SECS_PER_MIN;
        endcase
    end

    wire fits = (rem_reg >= divisor);
    wire last = (stage_reg == 2'h3) && !fits;
    csd_pkg::csd_time_type res_fin;
    assign res_fin = '{res_reg.year, res_reg.month, res_reg.day, res_reg.hour,
                       6'(q_reg), 6'(rem_reg)};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg       <= csd_pkg::CSD_IDLE;
            stage_reg       <= 2'h0;
            rem_reg         <= 17'h00000;
            hold_sec_reg    <= 17'h00000;
            q_reg           <= 7'h00;
            res_reg         <= '0;
            done_reg        <= 1'b0;
            diff_result_reg <= '0;
        end else begin
            done_reg <= last && !idle;
            if (idle) begin
                if (diff_do) begin
                    state_reg    <= csd_pkg::CSD_DIVIDE;
                    stage_reg    <= 2'h0;
                    rem_reg      <= future ? 17'h00000 : day_diff;
                    hold_sec_reg <= future ? 17'h00000 : sec_diff;
                    q_reg        <= 7'h00;
                end
            end else if (fits) begin
                rem_reg <= rem_reg - divisor;
                q_reg   <= q_reg + 7'h01;
            end else begin
                stage_reg <= stage_reg + 2'h1;
                q_reg     <= 7'h00;
                unique case (stage_reg)
                    2'h0: res_reg.year <= q_reg;
                    2'h1: begin
                        res_reg.month <= 4'(q_reg);
                        res_reg.day   <= 5'(rem_reg);
                        rem_reg       <= hold_sec_reg;
                    end
                    2'h2: res_reg.hour <= 5'(q_reg);
                    2'h3: begin
                        state_reg       <= csd_pkg::CSD_IDLE;
                        diff_result_reg <= csd_pkg::to_table(res_fin);
                    end
                endcase
            end
        end
    end

    assign load_error   = load_error_reg;
    assign diff_error   = diff_error_reg;
    assign diff_busy    = !idle;
    assign diff_done    = done_reg;
    assign diff_result  = diff_result_reg;
    assign current_time = cur_tab_reg;
    assign day_of_week  = dow_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_load_taken;
        load_do |=> now_reg == $past(load_time);
    endproperty
    a_load_taken: assert property (p_load_taken) else $error("valid load not applied");

    property p_load_kept;
        load_go && !load_ok && !tick |=> now_reg == $past(now_reg);
    endproperty
    a_load_kept: assert property (p_load_kept) else $error("invalid load changed clock");

    property p_load_flag;
        calendar_load_request && !load_ok |=> load_error;
    endproperty
    a_load_flag: assert property (p_load_flag) else $error("load error missing");

    property p_load_clean;
        calendar_load_request && load_ok |=> !load_error
            && (!$past(load_go) || current_time == $past(load_table));
    endproperty
    a_load_clean: assert property (p_load_clean) else $error("valid load flagged");

    property p_dow;
        load_do |-> ##2 day_of_week == $past(load_dow, 2);
    endproperty
    a_dow: assert property (p_dow) else $error("day of week wrong after load");

    property p_diff_ends;
        diff_do |=> diff_busy ##[1:260] diff_done;
    endproperty
    a_diff_ends: assert property (p_diff_ends) else $error("difference did not finish");

    property p_diff_refused;
        diff_go && !sub_ok |=> !diff_busy && diff_error;
    endproperty
    a_diff_refused: assert property (p_diff_refused) else $error("bad subtrahend ran");

    property p_diff_units;
        diff_done |-> diff_result.month[7:0] <= 8'h12 && diff_result.day[7:0] <= 8'h29
                      && diff_result.hour[7:0] <= 8'h23;
    endproperty
    a_diff_units: assert property (p_diff_units) else $error("result exceeds 30/365 units");

    property p_words;
        current_time.year[15:8] == 8'h00 && current_time.second[15:8] == 8'h00
        && diff_result.day[15:8] == 8'h00;
    endproperty
    a_words: assert property (p_words) else $error("upper byte not zero");

    c_load_ok:   cover property (load_do);
    c_load_bad:  cover property (load_go && !load_ok);
    c_diff_done: cover property (diff_done);
    c_diff_bad:  cover property (diff_go && !sub_ok);

endmodule
`default_nettype wire

// *** hw/csd_date_check.sv ***
/*
 Checks a six-word date/time table and converts it to binary fields,
 a day count from 2000-01-01, seconds of the day and the day of week.
 Purely combinational; the caller registers what it needs.
*/
`timescale 1ns/1ns
`default_nettype none
module csd_date_check (
    input  wire csd_pkg::csd_table_type table_in,
    output logic                        valid,
    output csd_pkg::csd_time_type       time_out,
    output logic [15:0]                 day_num,
    output logic [16:0]                 sec_of_day,
    output logic [2:0]                  dow
);
    logic [5:0]  word_ok;
    wire  [4:0]  dim;
    wire  [15:0] dow_sum;
    wire         leap_bump;
    wire  [6:0]  day_bin;

    // ----------------------------------------------------------------
    // Digit format: upper byte zero, both nibbles decimal
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 6; i++) begin : g_word
        wire [15:0] w = table_in[16*i +: 16];
        assign word_ok[i] = (w[15:8] == 8'h00) && (w[7:4] <= 4'h9) && (w[3:0] <= 4'h9);
    end

    assign time_out.year   = csd_pkg::bcd2bin(table_in.year[7:0]);
    assign time_out.month  = 4'(csd_pkg::bcd2bin(table_in.month[7:0]));
    assign time_out.day    = 5'(csd_pkg::bcd2bin(table_in.day[7:0]));
    assign time_out.hour   = 5'(csd_pkg::bcd2bin(table_in.hour[7:0]));
    assign time_out.minute = 6'(csd_pkg::bcd2bin(table_in.minute[7:0]));
    assign time_out.second = 6'(csd_pkg::bcd2bin(table_in.second[7:0]));

    // ----------------------------------------------------------------
    // Range checks
    // ----------------------------------------------------------------
    // Full width, so a day such as 35 cannot wrap into the legal range
    assign day_bin = csd_pkg::bcd2bin(table_in.day[7:0]);
    assign dim   = csd_pkg::days_in_month(time_out.year, time_out.month);
    assign valid = (&word_ok) && (table_in.month[7:0] >= 8'h01) && (table_in.month[7:0] <= 8'h12)
                && (day_bin >= 7'h01) && (day_bin <= 7'(dim))
                && (table_in.hour[7:0] <= 8'h23) && (table_in.minute[7:0] <= 8'h59)
                && (table_in.second[7:0] <= 8'h59);

    // ----------------------------------------------------------------
    // Linear day and second counts
    // ----------------------------------------------------------------
    assign leap_bump  = (time_out.year[1:0] == 2'h0) && (time_out.month > 4'h2);
    assign day_num    = 16'(time_out.year) * 16'h016d + 16'((time_out.year + 7'h03) >> 2)
                      + 16'(csd_pkg::days_before(time_out.month)) + 16'(leap_bump)
                      + 16'(time_out.day) - 16'h0001;
    assign sec_of_day = 17'(time_out.hour) * csd_pkg::SECS_PER_HOUR
                      + 17'(time_out.minute) * csd_pkg::SECS_PER_MIN + 17'(time_out.second);
    assign dow_sum    = day_num + csd_pkg::EPOCH_DOW;
    assign dow        = 3'(dow_sum % 16'h0007);

endmodule
`default_nettype wire

// *** hw/csd_pkg.sv ***
/*
 Shared types, constants and conversion functions of the calendar block.
 Assumes a single 25 MHz clock and two-digit years read as 2000 to 2099.
*/
`default_nettype none
package csd_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int     CLK_PERIOD_NS = 40;
    localparam longint SECOND_NS     = 64'd1000000000;
    localparam int     SEC_CYCLES    = int'(SECOND_NS / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Difference units and calendar constants
    // ----------------------------------------------------------------
    localparam logic [16:0] DAYS_PER_YEAR  = 17'h0016d;
    localparam logic [16:0] DAYS_PER_MONTH = 17'h0001e;
    localparam logic [16:0] SECS_PER_HOUR  = 17'h00e10;
    localparam logic [16:0] SECS_PER_MIN   = 17'h0003c;
    localparam logic [16:0] SECS_PER_DAY   = 17'h15180;
    // Day of week of 2000-01-01, Sunday counted as zero
    localparam logic [15:0] EPOCH_DOW      = 16'h0006;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // One word per field, BCD in the low byte
    typedef struct packed {
        logic [15:0] year;
        logic [15:0] month;
        logic [15:0] day;
        logic [15:0] hour;
        logic [15:0] minute;
        logic [15:0] second;
    } csd_table_type;

    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } csd_time_type;

    typedef enum {CSD_IDLE, CSD_DIVIDE} csd_state_type;

    localparam csd_time_type TIME_RESET = '{7'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00};

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [6:0] bcd2bin(input logic [7:0] v);
        return 7'(v[7:4] * 4'ha) + 7'(v[3:0]);
    endfunction

    function automatic logic [15:0] bin2bcd(input logic [6:0] v);
        logic [15:0] p;
        logic [3:0]  tens;
        p    = 16'(v) * 16'h00cd;
        tens = p[14:11];
        return {8'h00, tens, 4'(v - 7'(tens * 4'ha))};
    endfunction

    function automatic logic [4:0] days_in_month(input logic [6:0] y, input logic [3:0] m);
        unique case (m)
            4'h2:                      return (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb:    return 5'h1e;
            default:                   return 5'h1f;
        endcase
    endfunction

    // Days before the first of each month in a common year
    function automatic logic [8:0] days_before(input logic [3:0] m);
        unique case (m)
            4'h2: return 9'h01f;  4'h3: return 9'h03b;  4'h4: return 9'h05a;
            4'h5: return 9'h078;  4'h6: return 9'h097;  4'h7: return 9'h0b5;
            4'h8: return 9'h0d4;  4'h9: return 9'h0f3;  4'ha: return 9'h111;
            4'hb: return 9'h130;  4'hc: return 9'h14e;
            default: return 9'h000;
        endcase
    endfunction

    function automatic csd_table_type to_table(input csd_time_type t);
        return '{bin2bcd(t.year), bin2bcd(7'(t.month)), bin2bcd(7'(t.day)),
                 bin2bcd(7'(t.hour)), bin2bcd(7'(t.minute)), bin2bcd(7'(t.second))};
    endfunction

endpackage
`default_nettype wire

// *** testbench/csd_calendar_tb.sv ***
/*
 Self-checking bench of the calendar block: reset, loads, differences.
 Assumes the seconds prescaler is shortened to 20 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module csd_calendar_tb;
    localparam int SEC = 20;

    logic                   clk;
    logic                   reset;
    logic                   ld_go;
    logic                   df_go;
    logic [7:0]             ld_hold;
    logic [7:0]             df_hold;
    csd_pkg::csd_table_type ld_tab;
    csd_pkg::csd_table_type df_tab;
    logic                   ld_req;
    logic                   df_req;
    csd_pkg::csd_table_type load_table;
    csd_pkg::csd_table_type subtrahend_table;
    logic                   load_error;
    logic                   diff_error;
    logic                   diff_busy;
    logic                   diff_done;
    csd_pkg::csd_table_type diff_result;
    csd_pkg::csd_table_type current_time;
    logic [2:0]             day_of_week;
    int                     n_fail;
    int                     checks_done;

    csd_calendar #(.SEC_CYCLES(SEC)) u_csd_calendar (
        .clk(clk), .reset(reset), .calendar_load_request(ld_req), .load_table(load_table),
        .calendar_difference_request(df_req), .subtrahend_table(subtrahend_table),
        .load_error(load_error), .diff_error(diff_error), .diff_busy(diff_busy),
        .diff_done(diff_done), .diff_result(diff_result), .current_time(current_time),
        .day_of_week(day_of_week));
    csd_requester u_ld (.clk(clk), .go(ld_go), .table_in(ld_tab), .hold_cycles(ld_hold),
        .request(ld_req), .table_out(load_table));
    csd_requester u_df (.clk(clk), .go(df_go), .table_in(df_tab), .hold_cycles(df_hold),
        .request(df_req), .table_out(subtrahend_table));

    initial clk = 1'b0;
    always #20 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Returns at the falling edge where the request has just risen
    task automatic send(input logic is_load, input logic [95:0] t, input logic [7:0] hold);
        @(negedge clk);
        if (is_load) begin
            ld_tab  <= t;
            ld_hold <= hold;
            ld_go   <= 1'b1;
        end else begin
            df_tab  <= t;
            df_hold <= hold;
            df_go   <= 1'b1;
        end
        @(negedge clk);
        ld_go <= 1'b0;
        df_go <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        repeat (3) @(negedge clk);
        check("time after reset", 96'h0000_0001_0001_0000_0000_0000, current_time);
        check("dow after reset", 96'h6, day_of_week);
    endtask

    task automatic t_bad_loads;
        logic [95:0] bad [6];
        bad = '{96'h0000_0013_0001_0000_0000_0000, 96'h0000_0002_0030_0000_0000_0000,
                96'h0000_0001_0001_0024_0000_0000, 96'h0000_0001_0001_0000_005a_0000,
                96'h0000_0001_0001_0000_0000_0100, 96'h0000_0001_0035_0000_0000_0000};
        for (int i = 0; i < 6; i++) begin
            send(1'b1, bad[i], 8'h03);
            repeat (2) @(negedge clk);
            check("load_error bad", 96'h1, load_error);
            check("date kept", 96'h0000_0001_0001, current_time[95:48]);
            repeat (5) @(negedge clk);
            check("load_error idle", 96'h0, load_error);
        end
    endtask

    task automatic t_good_load;
        send(1'b1, 96'h0098_0001_0015_0016_0059_0059, 8'h06);
        repeat (4) @(negedge clk);
        check("loaded time", 96'h0098_0001_0015_0016_0059_0059, current_time);
        check("load_error good", 96'h0, load_error);
        check("dow loaded", 96'h3, day_of_week);
        repeat (24) @(negedge clk);
        check("time after tick", 96'h0098_0001_0015_0017_0000_0000, current_time);
    endtask

    task automatic t_diff;
        int n;
        send(1'b0, 96'h0097_0010_0010_0015_0030_0000, 8'h03);
        @(negedge clk);
        check("busy", 96'h1, diff_busy);
        n = 0;
        while (diff_done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("done seen", 96'h1, diff_done);
        check("difference", 96'h0000_0003_0007_0001_0030_0000, diff_result);
        check("diff_error good", 96'h0, diff_error);
    endtask

    task automatic t_bad_diff;
        repeat (3) @(negedge clk);
        send(1'b0, 96'h0097_0010_0010_0024_0030_0000, 8'h03);
        repeat (2) @(negedge clk);
        check("diff_error bad", 96'h1, diff_error);
        check("busy bad", 96'h0, diff_busy);
        repeat (300) @(negedge clk);
        check("result kept", 96'h0000_0003_0007_0001_0030_0000, diff_result);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_fail      = 0;
        checks_done = 0;
        reset       = 1'b1;
        ld_go       = 1'b0;
        df_go       = 1'b0;
        ld_hold     = 8'h00;
        df_hold     = 8'h00;
        ld_tab      = '0;
        df_tab      = '0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_bad_loads();
        t_good_load();
        t_diff();
        t_bad_diff();
        give_verdict();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire

// *** testbench/csd_requester.sv ***
/*
 Model of the user program that raises one kind of calendar request.
 Assumes the bench pulses go at a falling edge with the table set up.
*/
`timescale 1ns/1ns
`default_nettype none
module csd_requester (
    input  wire logic                   clk,
    input  wire logic                   go,
    input  wire csd_pkg::csd_table_type table_in,
    input  wire logic [7:0]             hold_cycles,
    output logic                        request,
    output csd_pkg::csd_table_type      table_out
);
    logic                   req_reg  = 1'b0;
    csd_pkg::csd_table_type tab_reg  = '0;
    logic [7:0]             left_reg = 8'h00;

    assign request   = req_reg;
    assign table_out = tab_reg;

    // ------------------------------------------------------------
    // Request sequencing
    // ------------------------------------------------------------
    // Table is stable while the request stands; inverted once released
    // so that a block sampling too late sees garbage, not the old table.
    always @(negedge clk) begin
        if (go && !req_reg) begin
            req_reg  <= 1'b1;
            tab_reg  <= table_in;
            left_reg <= hold_cycles;
        end else if (req_reg && left_reg == 8'h00) begin
            req_reg <= 1'b0;
            tab_reg <= ~tab_reg;
        end else if (req_reg) begin
            left_reg <= left_reg - 8'h01;
        end
    end
endmodule
`default_nettype wire
